/* File: inc/bmb_pkg.sv */
package bmb_pkg;

  // ==========================================================
  // bus widths
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 16;
  localparam int UPPER_W = 16;
  localparam int BEAT_W  = 3;
  localparam int BE_W    = 2;
  localparam int MAX_BEATS = 8;
  localparam int WDATA_W = DATA_W * MAX_BEATS;
  localparam int UPPER_LSB = 16;
  localparam int WORD_LSB  = 1;
  localparam int WORD_SHIFT_W = 4;

  // ==========================================================
  // levels and codes
  localparam logic LEVEL_HIGH = 1'b1;
  localparam logic LEVEL_LOW  = 1'b0;
  localparam logic [BEAT_W-1:0] BEAT_ZERO = 3'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE  = 3'h1;
  localparam logic [BE_W-1:0] LANES_OFF_N = 2'h3;
  localparam logic [BE_W-1:0] LANES_ALL_N = 2'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [UPPER_W-1:0] UPPER_ZERO = 16'h0000;
  localparam logic [WORD_SHIFT_W-1:0] WORD_SHIFT_PAD = 4'h0;

  // ==========================================================
  // bus states
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_DATA,
    BUS_HOLD
  } bus_state_e;

endpackage

/* File: core/burst_muxed_bus_interface.sv */
`timescale 1ns/1ps
// Functional notes
// - internal clock is input clock halved; bus states advance only on it
// - upper sixteen address lines driven and held stable through whole burst
// - low address then data share muxed lines; data follows address cycle
// - burst word address lines step to each next half-word in burst
// - in address cycle word address lines equal muxed lines bits 3 to 1
// - latch strobe high in address cycle, dropped before data cycle begins
// - latch strobe active high and floated during hold cycle
// - address state strobe low each address cycle, high in following data cycle
// - under reset state strobe, data enable and direction all driven high
// - write/read shown in address cycle and held through data cycles
// - data enable low during data cycles while data moves
// - device releases muxed lines no later than data enable assertion
// - data enable released only once read data has been captured
// - direction low for reads and acknowledges, high for writes
// - direction never changes while data enable is low
// - ready absent in data cycle inserts wait cycle, sampled again next
// - one burst carries at most eight half-words
// - byte lane selects asserted per data cycle for active lanes
module burst_muxed_bus_interface
(
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          reqValid,
  input  wire logic                          reqWrite,
  input  wire logic                          reqIntAck,
  input  wire logic [bmb_pkg::ADDR_W-1:0]    reqAddr,
  input  wire logic [bmb_pkg::BEAT_W-1:0]    reqLastBeat,
  input  wire logic [bmb_pkg::BE_W-1:0]      reqFirstLanes_n,
  input  wire logic [bmb_pkg::BE_W-1:0]      reqLastLanes_n,
  input  wire logic [bmb_pkg::WDATA_W-1:0]   reqWrData,
  input  wire logic                          holdReq,
  input  wire logic                          ready_n,
  input  wire logic [bmb_pkg::DATA_W-1:0]    adIn,
  output logic                               reqTaken,
  output logic [bmb_pkg::DATA_W-1:0]         rdData,
  output logic                               rdValid,
  output logic [bmb_pkg::BEAT_W-1:0]         rdBeat,
  output logic                               burstDone,
  output logic                               holdAck,
  output logic                               busOe,
  output logic [bmb_pkg::UPPER_W-1:0]        upperAddr,
  output logic [bmb_pkg::DATA_W-1:0]         adOut,
  output logic                               adOe,
  output logic [bmb_pkg::BEAT_W-1:0]         burstWordAddr,
  output logic                               addressLatchStrobe,
  output logic                               addressStateStrobe_n,
  output logic                               dataPhaseEnable_n,
  output logic                               writeNotRead,
  output logic                               transceiverDirection,
  output logic [bmb_pkg::BE_W-1:0]           byteLaneSelects_n
);
  import bmb_pkg::*;

  // ==========================================================
  // state
  bus_state_e               stateReg;
  bus_state_e               stateNext;
  logic                     phaseReg;
  logic [BEAT_W-1:0]        beatReg;
  logic [BEAT_W-1:0]        beatNext;
  logic [BEAT_W-1:0]        lastBeatReg;
  logic                     writeReg;
  logic [BE_W-1:0]          firstLanesReg;
  logic [BE_W-1:0]          lastLanesReg;
  logic [WDATA_W-1:0]       wrBufReg;

  // ==========================================================
  // decode
  wire tick      = phaseReg;
  wire inIdle    = (stateReg == BUS_IDLE);
  wire inAddr    = (stateReg == BUS_ADDR);
  wire inData    = (stateReg == BUS_DATA);
  wire inHold    = (stateReg == BUS_HOLD);
  wire beatDone  = inData && tick && !ready_n;
  wire lastBeat  = (beatReg == lastBeatReg);
  wire lastDone  = beatDone && lastBeat;
  wire stepBeat  = beatDone && !lastBeat;
  wire freeSlot  = (inIdle && tick) || lastDone;
  wire accept    = freeSlot && reqValid && !holdReq;
  wire goHold    = inIdle && tick && holdReq;
  wire leaveHold = inHold && tick && !holdReq;
  wire nextAddr  = (stateNext == BUS_ADDR);
  wire nextData  = (stateNext == BUS_DATA);
  wire enterData = inAddr && tick;
  wire [WORD_SHIFT_W+BEAT_W-1:0] wordBase = {beatNext, WORD_SHIFT_PAD};
  wire [DATA_W-1:0] wrWord = wrBufReg[wordBase +: DATA_W];
  wire [BE_W-1:0] lanesNext =
    (beatNext == BEAT_ZERO)   ? firstLanesReg :
    (beatNext == lastBeatReg) ? lastLanesReg  :
                                LANES_ALL_N;

  // ==========================================================
  // pin values
  wire               reqIsWrite = reqWrite && !reqIntAck;
  wire [UPPER_W-1:0] reqUpper   = reqAddr[UPPER_LSB +: UPPER_W];
  wire [BEAT_W-1:0]  reqWord    = reqAddr[WORD_LSB +: BEAT_W];
  wire [DATA_W-1:0]  reqLow     = reqAddr[DATA_W-1:0];
  wire [BEAT_W-1:0]  wordStep   = burstWordAddr + BEAT_ONE;
  wire               adDrive    = nextAddr || (nextData && writeReg);
  wire [BE_W-1:0]    lanesPin   = nextData ? lanesNext : LANES_OFF_N;
  wire               capture    = beatDone && !writeReg;
  wire               holdNext   = (stateNext == BUS_HOLD);

  // next bus state
  always_comb
  begin
    stateNext = stateReg;
    unique case (stateReg)
      BUS_IDLE:
        if (accept)
          stateNext = BUS_ADDR;
        else if (goHold)
          stateNext = BUS_HOLD;
      BUS_ADDR:
        if (enterData)
          stateNext = BUS_DATA;
      BUS_DATA:
        if (accept)
          stateNext = BUS_ADDR;
        else if (lastDone)
          stateNext = BUS_IDLE;
      BUS_HOLD:
        if (leaveHold)
          stateNext = BUS_IDLE;
    endcase
  end

  // word counter within the burst
  assign beatNext =
    accept   ? BEAT_ZERO :
    stepBeat ? beatReg + BEAT_ONE :
               beatReg;

  // ==========================================================
  // internal clock enable
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      phaseReg <= LEVEL_LOW;
    else
      phaseReg <= !phaseReg;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= BUS_IDLE;
      beatReg  <= BEAT_ZERO;
    end
    else
    begin
      stateReg <= stateNext;
      beatReg  <= beatNext;
    end
  end

  // ==========================================================
  // request capture
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastBeatReg   <= BEAT_ZERO;
      writeReg      <= LEVEL_LOW;
      firstLanesReg <= LANES_OFF_N;
      lastLanesReg  <= LANES_OFF_N;
      wrBufReg      <= '0;
    end
    else if (accept)
    begin
      lastBeatReg   <= reqLastBeat;
      writeReg      <= reqIsWrite;
      firstLanesReg <= reqFirstLanes_n;
      lastLanesReg  <= reqLastLanes_n;
      wrBufReg      <= reqWrData;
    end
  end

  // ==========================================================
  // address pins
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upperAddr     <= UPPER_ZERO;
      burstWordAddr <= BEAT_ZERO;
    end
    else if (accept)
    begin
      upperAddr     <= reqUpper;
      burstWordAddr <= reqWord;
    end
    else if (stepBeat)
      burstWordAddr <= wordStep;
  end

  // ==========================================================
  // muxed address and data lines
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adOut <= DATA_ZERO;
      adOe  <= LEVEL_LOW;
    end
    else
    begin
      if (accept)
        adOut <= reqLow;
      else if (enterData || stepBeat)
        adOut <= wrWord;
      adOe <= adDrive;
    end
  end

  // ==========================================================
  // strobes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addressLatchStrobe   <= LEVEL_LOW;
      addressStateStrobe_n <= LEVEL_HIGH;
      dataPhaseEnable_n    <= LEVEL_HIGH;
      byteLaneSelects_n    <= LANES_OFF_N;
    end
    else
    begin
      addressLatchStrobe   <= accept;
      addressStateStrobe_n <= !nextAddr;
      dataPhaseEnable_n    <= !nextData;
      byteLaneSelects_n    <= lanesPin;
    end
  end

  // ==========================================================
  // direction and write/read, loaded only at the address cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      transceiverDirection <= LEVEL_HIGH;
      writeNotRead         <= LEVEL_LOW;
    end
    else if (accept)
    begin
      transceiverDirection <= reqIsWrite;
      writeNotRead         <= reqIsWrite;
    end
  end

  // ==========================================================
  // hold and float
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busOe   <= LEVEL_HIGH;
      holdAck <= LEVEL_LOW;
    end
    else
    begin
      busOe   <= !holdNext;
      holdAck <= holdNext;
    end
  end

  // ==========================================================
  // user side answers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData  <= DATA_ZERO;
      rdValid <= LEVEL_LOW;
      rdBeat  <= BEAT_ZERO;
    end
    else
    begin
      rdValid <= capture;
      if (capture)
      begin
        rdData <= adIn;
        rdBeat <= beatReg;
      end
    end
  end

  // ==========================================================
  // request and burst pulses
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reqTaken  <= LEVEL_LOW;
      burstDone <= LEVEL_LOW;
    end
    else
    begin
      reqTaken  <= accept;
      burstDone <= lastDone;
    end
  end

endmodule

/* File: verification/burst_muxed_bus_interface_assertions.sv */
`timescale 1ns/1ps
// ==========
// bus protocol checker
module burst_muxed_bus_interface_assertions
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        ready_n,
  input wire logic        rdValid,
  input wire logic        adOe,
  input wire logic [15:0] adOut,
  input wire logic [2:0]  burstWordAddr,
  input wire logic        addressLatchStrobe,
  input wire logic        addressStateStrobe_n,
  input wire logic        dataPhaseEnable_n,
  input wire logic        writeNotRead,
  input wire logic        transceiverDirection,
  input wire logic [15:0] upperAddr,
  input wire logic [1:0]  byteLaneSelects_n,
  input wire logic        holdAck,
  input wire logic        busOe
);
  import bmb_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  AST_ALE_AS: assert property (addressLatchStrobe |-> !addressStateStrobe_n && adOe)
    else $error("latch strobe outside address cycle");
  AST_AS_SEQ: assert property ($fell(addressStateStrobe_n) |=> !addressStateStrobe_n
    ##1 (addressStateStrobe_n && !dataPhaseEnable_n)) else $error("address cycle shape");
  AST_WORD_EQ: assert property (!addressStateStrobe_n |-> burstWordAddr == adOut[3:1])
    else $error("word address differs");
  AST_STEP: assert property (!dataPhaseEnable_n && !$past(dataPhaseEnable_n)
    && $changed(burstWordAddr) |-> burstWordAddr == $past(burstWordAddr) + 3'h1)
    else $error("word address step");
  AST_RELEASE: assert property (!dataPhaseEnable_n && !writeNotRead |-> !adOe)
    else $error("lines driven in read data");
  AST_DIR_WR: assert property ((!addressStateStrobe_n || !dataPhaseEnable_n)
    |-> transceiverDirection == writeNotRead) else $error("direction wrong");
  AST_DIR_HOLD: assert property (!dataPhaseEnable_n |=> dataPhaseEnable_n
    || $stable(transceiverDirection)) else $error("direction changed");
  AST_WAIT: assert property (rdValid |-> !$past(ready_n) && !$past(dataPhaseEnable_n))
    else $error("capture without ready");
  AST_ALE_ONE: assert property (addressLatchStrobe |=> !addressLatchStrobe)
    else $error("latch strobe longer than one clock");
  AST_UPPER: assert property ((!dataPhaseEnable_n || (!addressStateStrobe_n
    && !addressLatchStrobe)) |-> $stable(upperAddr)) else $error("upper address moved");
  AST_LANES_OFF: assert property (dataPhaseEnable_n |-> byteLaneSelects_n == 2'h3)
    else $error("lanes active outside data");
  AST_WAIT_HOLD: assert property (!dataPhaseEnable_n && ready_n |=> !dataPhaseEnable_n)
    else $error("data cycle ended without ready");
  AST_HOLD_FLOAT: assert property (holdAck |-> !busOe && !addressLatchStrobe)
    else $error("pins driven in hold");
  cover property (rdValid);
  cover property (holdAck);
  cover property (!dataPhaseEnable_n && writeNotRead && ready_n);
  cover property ($rose(dataPhaseEnable_n) && !addressStateStrobe_n);
endmodule
bind burst_muxed_bus_interface burst_muxed_bus_interface_assertions chk (.core_clk, .rst_n,
  .ready_n, .rdValid, .adOe, .adOut, .burstWordAddr, .addressLatchStrobe,
  .addressStateStrobe_n, .dataPhaseEnable_n, .writeNotRead, .transceiverDirection,
  .upperAddr, .byteLaneSelects_n, .holdAck, .busOe);

/* File: verification/mem_model.sv */
`timescale 1ns/1ps
// ==========
// far-side memory with address latch and random waits
module mem_model
(
  input  wire logic        core_clk,
  input  wire logic        addressLatchStrobe,
  input  wire logic        dataPhaseEnable_n,
  input  wire logic        writeNotRead,
  input  wire logic [15:0] adOut,
  input  wire logic [2:0]  burstWordAddr,
  output logic             ready_n = 1'b1,
  output logic [15:0]      adIn
);
  logic [15:0] lowAddr_reg = 16'h0000;
  logic [15:0] lastAd_reg = 16'h0000;
  integer      seed = 32'h1c0f;
  wire         driveBus = !dataPhaseEnable_n && !writeNotRead;
  assign adIn = driveBus ? {lowAddr_reg[15:4], burstWordAddr, 1'b1} : ~lastAd_reg;
  always @(posedge core_clk)
  begin
    if (addressLatchStrobe)
      lowAddr_reg <= adOut;
    ready_n <= dataPhaseEnable_n | 1'($random(seed));
    lastAd_reg <= adIn;
  end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
// ==========
// random bursts against the memory model
module testbench;
  import bmb_pkg::*;
  logic               core_clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
  logic               reqIntAck = 1'b0, holdReq = 1'b0, rw, pDen = 1'b1, pWr = 1'b0;
  logic [ADDR_W-1:0]  reqAddr = '0, a;
  logic [BEAT_W-1:0]  reqLastBeat = '0, rdBeat, burstWordAddr, pBwa, lb;
  logic [WDATA_W-1:0] reqWrData = '0, wd;
  logic [DATA_W-1:0]  adIn, rdData, adOut, pAd;
  logic [DATA_W-1:0]  expQ[$];
  logic [BE_W-1:0]    reqFirstLanes_n = '0, reqLastLanes_n = '0, fl, ll, pBe = '1, laneQ[$];
  logic [BEAT_W-1:0]  bQ[$];
  logic [31:0]        tkQ[$], lbQ[$];
  int                 nBeats = 0;
  logic [UPPER_W-1:0] upperAddr;
  logic [BE_W-1:0]    byteLaneSelects_n;
  logic               ready_n, reqTaken, rdValid, burstDone, holdAck, busOe, adOe;
  logic               addressLatchStrobe, addressStateStrobe_n, dataPhaseEnable_n;
  logic               writeNotRead, transceiverDirection;
  int                 n_errors = 0, compares = 0;
  integer             seed = 32'h1c0f;
  wire  [31:0]        takenPins = {14'h0, transceiverDirection, writeNotRead, upperAddr};
  burst_muxed_bus_interface dut (.core_clk, .rst_n, .reqValid, .reqWrite, .reqIntAck, .reqAddr,
    .reqLastBeat, .reqFirstLanes_n, .reqLastLanes_n, .reqWrData,
    .holdReq, .ready_n, .adIn, .reqTaken, .rdData, .rdValid, .rdBeat, .burstDone, .holdAck,
    .busOe, .upperAddr, .adOut, .adOe, .burstWordAddr, .addressLatchStrobe,
    .addressStateStrobe_n, .dataPhaseEnable_n, .writeNotRead, .transceiverDirection,
    .byteLaneSelects_n);
  mem_model mem (.core_clk, .addressLatchStrobe, .dataPhaseEnable_n, .writeNotRead, .adOut,
    .burstWordAddr, .ready_n, .adIn);
  always #4 core_clk = ~core_clk;
  task automatic test_done();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stall(input int i, input int lim);
    if (i >= lim)
    begin
      check("wait", 16'h0001, 16'h0000);
      test_done();
    end
  endtask
  // ==========
  // watcher: pops the oldest note on each result
  always @(posedge core_clk)
  begin
    if (rdValid)
    begin
      check("read word", expQ.size() ? expQ.pop_front() : 'x, rdData);
      check("read beat", bQ.size() ? bQ.pop_front() : 'x, rdBeat);
      check("read lanes", laneQ.size() ? laneQ.pop_front() : 'x, pBe);
      nBeats++;
    end
    if (!pDen && pWr && (dataPhaseEnable_n || burstWordAddr != pBwa))
    begin
      check("write word", expQ.size() ? expQ.pop_front() : 'x, pAd);
      check("write lanes", laneQ.size() ? laneQ.pop_front() : 'x, pBe);
      nBeats++;
    end
    if (reqTaken)
      check("taken", tkQ.size() ? tkQ.pop_front() : 'x, takenPins);
    if (burstDone)
    begin
      check("burst beats", lbQ.size() ? lbQ.pop_front() : 'x, nBeats);
      nBeats = 0;
    end
    pBe <= byteLaneSelects_n;
    pDen <= dataPhaseEnable_n;
    pWr <= writeNotRead;
    pBwa <= burstWordAddr;
    pAd <= adOut;
  end
  // ==========
  // driver
  initial
  begin
    repeat (6) @(posedge core_clk);
    check("state strobe", 16'h0001, addressStateStrobe_n);
    check("data enable", 16'h0001, dataPhaseEnable_n);
    check("direction", 16'h0001, transceiverDirection);
    rst_n <= 1'b1;
    for (int b = 0; b < 16; b++)
    begin
      @(posedge core_clk);
      rw = 1'($random(seed));
      lb = (b == 0) ? 3'h7 : (b == 1) ? 3'h0 : 3'($random(seed));
      a = $random(seed);
      wd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      fl = 2'(($random(seed) & 32'h7fff) % 3);
      ll = 2'(($random(seed) & 32'h7fff) % 3);
      reqFirstLanes_n <= fl;
      reqLastLanes_n <= ll;
      reqValid <= 1'b1;
      reqWrite <= rw;
      reqIntAck <= !rw && b[1];
      reqAddr <= a;
      reqLastBeat <= lb;
      reqWrData <= wd;
      tkQ.push_back({14'h0, rw, rw, a[31:16]});
      lbQ.push_back(32'(lb) + 32'h1);
      for (int k = 0; k <= lb; k++)
      begin
        expQ.push_back(rw ? wd[16*k+:16] : {a[15:4], 3'(a[3:1] + k), 1'b1});
        laneQ.push_back((k == 0) ? fl : (k == lb) ? ll : LANES_ALL_N);
        if (!rw)
          bQ.push_back(3'(k));
      end
      for (int i = 0; !reqTaken; i++)
      begin
        stall(i, 400);
        @(posedge core_clk);
      end
    end
    @(posedge core_clk);
    reqValid <= 1'b0;
    for (int i = 0; expQ.size() != 0; i++)
    begin
      stall(i, 800);
      @(posedge core_clk);
    end
    holdReq <= 1'b1;
    for (int i = 0; !holdAck; i++)
    begin
      stall(i, 50);
      @(posedge core_clk);
    end
    check("bus enable in hold", 16'h0000, busOe);
    holdReq <= 1'b0;
    repeat (4) @(posedge core_clk);
    test_done();
  end
endmodule
